/* bench/pwmos_fault_src.sv */
// model of the external fault sources, wire-combined onto the two inputs
`timescale 1ns/1ns
module pwmos_fault_src (
  input  wire logic [1:0] i_src_a,     // sources on input a, 1 = fault
  input  wire logic       i_src_b,     // source on input b, 1 = fault
  output logic            o_fault_a_n, // wired input a, active low
  output logic            o_fault_b_n  // wired input b, active low
);
  // any source pulling low wins, as on an open-drain wire
  assign o_fault_a_n = ~|i_src_a;
  assign o_fault_b_n = ~i_src_b;
endmodule

/* bench/pwmos_top_bench.sv */
// self-checking bench for the pwm output polarity and fault stage
`timescale 1ns/1ns
module pwmos_top_bench;
  import pwmos_pkg::*;
  logic              i_clk = 0;
  logic              i_rst = 1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic              i_wr = 0;
  logic              i_rd = 0;
  logic [DATA_W-1:0] o_rdata;
  logic              hp = 1;
  logic              lp = 1;
  logic              i_rcfg = 0;
  logic [1:0]        src_a = 0;
  logic              src_b = 0;
  logic              fa_n;
  logic              fb_n;
  logic [7:0]        i_duty = 0;
  logic              i_per = 0;
  logic [7:0]        i_pdat = 0;
  logic [7:0]        i_dir = 0;
  logic [7:0]        i_pin = 0;
  logic [7:0]        o_pin_out;
  logic [7:0]        o_pin_oe_n;
  logic              o_irq;
  logic [7:0]        sel = 8'hff;
  logic [7:0]        man = 8'h00;
  logic [2:0]        pen;
  logic [31:0]       d;
  int                seed = 9;
  int                fail_count = 0;
  int                checks = 0;

  always #2 i_clk = ~i_clk;

  pwmos_fault_src u_src (.i_src_a(src_a), .i_src_b(src_b), .o_fault_a_n(fa_n),
    .o_fault_b_n(fb_n));
  pwmos_top #(.NUM_OUTPUTS(8)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_high_side_polarity(hp), .i_low_side_polarity(lp),
    .i_reset_pin_state_cfg(i_rcfg), .i_fault_in_a_n(fa_n), .i_fault_in_b_n(fb_n),
    .i_duty_pwm(i_duty), .i_period_start(i_per), .i_port_data(i_pdat),
    .i_pin_direction_reg(i_dir), .i_pin_in(i_pin), .o_pin_out(o_pin_out),
    .o_pin_oe_n(o_pin_oe_n), .o_irq(o_irq));

  task automatic give_verdict();
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1;
    @(posedge i_clk);
    i_wr <= 0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1;
    @(posedge i_clk);
    i_rd <= 0;
    #1 d = o_rdata;
  endtask

  task automatic period();
    @(posedge i_clk);
    i_per <= 1;
    @(posedge i_clk);
    i_per <= 0;
  endtask

  task automatic do_reset(input logic cfg);
    @(posedge i_clk);
    i_rst <= 1;
    i_rcfg <= cfg;
    cyc(20);
    i_rst <= 0;
    pen = cfg ? PEN_OFF : PEN_RST_8;
    sel = OVR_CTL_RST;
    man = OVR_ST_RST;
  endtask

  task automatic rnd();
    @(posedge i_clk);
    i_duty <= 8'($random(seed));
    i_pdat <= 8'($random(seed));
    i_dir <= 8'($random(seed));
    i_pin <= 8'($random(seed));
  endtask

  function automatic logic [7:0] en_mask(input logic [2:0] p);
    case (p)
      3'h0: return 8'h00;
      3'h1: return 8'h02;
      3'h2: return 8'h03;
      3'h3: return 8'h0f;
      3'h4: return 8'h3f;
      default: return 8'hff;
    endcase
  endfunction

  // pins expected for the given forced mask; inactive level is ~polarity
  function automatic logic [15:0] exp_pins(input logic [7:0] fm);
    logic [7:0] pol;
    logic [7:0] lvl;
    logic [7:0] m;
    pol = {4{hp, lp}};
    m = en_mask(pen);
    lvl = ((sel & i_duty) | (~sel & man)) & ~fm;
    return {(i_dir & ~m), (m & ~(lvl ^ pol)) | (~m & i_pdat)};
  endfunction

  task automatic chk_pins(input logic [7:0] fm);
    chk({o_pin_oe_n, o_pin_out}, exp_pins(fm));
  endtask

  initial begin
    do_reset(0);
    rnd();
    cyc(4);
    rd(OFS_CTRL0);
    chk(d, 32'h5);
    rd(OFS_PIN_STAT);
    chk(d, {16'h0, i_pin, 8'h03});
    chk_pins(8'h00);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      {hp, lp} <= k[1:0];
      rnd();
      cyc(5);
      chk_pins(8'h00);
    end
    for (int k = 0; k < 8; k++) begin
      pen = k[2:0];
      wr(OFS_CTRL0, k);
      rnd();
      cyc(3);
      chk_pins(8'h00);
    end
    pen = 3'h5;
    wr(OFS_CTRL0, 32'h5);
    for (int k = 0; k < 4; k++) begin
      sel = 8'($random(seed));
      man = 8'($random(seed));
      wr(OFS_OVR_CTL, {24'h0, sel});
      wr(OFS_OVR_ST, {24'h0, man});
      {hp, lp} <= k[1:0];
      rnd();
      cyc(5);
      chk_pins(8'h00);
      rd(OFS_OVR_CTL);
      chk(d, {24'h0, sel});
    end
    sel = 8'hff;
    wr(OFS_OVR_CTL, 32'hff);
    // latched fault a, full scope, interrupt unmasked
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_FLT_CFG, 32'h11);
    src_a <= 2'h1;
    cyc(6);
    chk_pins(8'hff);
    chk(o_irq, 1);
    rd(OFS_FLT_CFG);
    chk(d[FB_STAT_A], 1);
    src_a <= 2'h0;
    cyc(4);
    period();
    cyc(3);
    chk_pins(8'hff);
    rd(OFS_PIN_STAT);
    chk(d, {16'h0, i_pin, 8'h0b});
    wr(OFS_FLT_CFG, 32'h31);
    cyc(3);
    chk_pins(8'hff);
    period();
    cyc(3);
    chk_pins(8'h00);
    wr(OFS_IRQ_STAT, 32'h1);
    cyc(3);
    chk(o_irq, 0);
    // cycle-by-cycle fault b, partial scope, interrupt masked
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_FLT_CFG, 32'h0a);
    src_b <= 1;
    cyc(6);
    chk_pins(8'h3f);
    chk(o_irq, 0);
    rd(OFS_IRQ_STAT);
    chk(d[1:0], 2'h2);
    src_b <= 0;
    cyc(4);
    period();
    cyc(3);
    chk_pins(8'h00);
    rd(OFS_FLT_CFG);
    chk(d[FB_STAT_B], 0);
    // both enables off: the second source on input a is ignored
    wr(OFS_FLT_CFG, 32'h10);
    src_a <= 2'h2;
    cyc(6);
    chk_pins(8'h00);
    src_a <= 2'h0;
    rd(8'h3c);
    chk(d, 0);
    do_reset(1);
    rnd();
    cyc(4);
    rd(OFS_CTRL0);
    chk(d, 32'h0);
    rd(OFS_PIN_STAT);
    chk(d, {16'h0, i_pin, 8'h07});
    chk_pins(8'h00);
    give_verdict();
  end

  initial begin
    #40000;
    fail_count++;
    give_verdict();
  end
endmodule

/* common/pwmos_pkg.sv */
// shared constants for the pwm output polarity and fault stage
package pwmos_pkg;
  localparam int unsigned NUM_PINS   = 8;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL0    = 8'h00;
  localparam logic [7:0] OFS_FLT_CFG  = 8'h04;
  localparam logic [7:0] OFS_OVR_CTL  = 8'h08;
  localparam logic [7:0] OFS_OVR_ST   = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_PIN_STAT = 8'h18;

  // fault configuration field positions
  localparam int unsigned FB_EN_A    = 0;
  localparam int unsigned FB_EN_B    = 1;
  localparam int unsigned FB_MODE_A  = 2;
  localparam int unsigned FB_MODE_B  = 3;
  localparam int unsigned FB_SCOPE   = 4;
  localparam int unsigned FB_STAT_A  = 5;
  localparam int unsigned FB_STAT_B  = 6;

  // pin status readback field positions
  localparam int unsigned PB_HIGH_SIDE_POLARITY    = 0;
  localparam int unsigned PB_LOW_SIDE_POLARITY    = 1;
  localparam int unsigned PB_RSTCFG  = 2;
  localparam int unsigned PB_SHUT_A  = 3;
  localparam int unsigned PB_SHUT_B  = 4;
  localparam int unsigned PB_PINS    = 8;

  // reset values
  localparam logic [2:0] PEN_OFF      = 3'h0;
  localparam logic [2:0] PEN_RST_8    = 3'h5;
  localparam logic [2:0] PEN_RST_6    = 3'h4;
  localparam logic [7:0] OVR_CTL_RST  = 8'hff;
  localparam logic [7:0] OVR_ST_RST   = 8'h00;
  localparam logic       SCOPE_RST    = 1'b1;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // fault input mode encoding
  localparam logic MODE_LATCHED = 1'b0;
  localparam logic MODE_CYCLE   = 1'b1;
endpackage

/* rtl/pwmos_top.sv */
// pwm output stage: pin ownership, polarity, override, fault shutdown, registers
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ns

// Overview of operation
// RULE1: high-side polarity bit sets odd output polarity
// RULE2: low-side polarity bit sets even output polarity
// RULE3: forced and override levels also pass polarity
// RULE4: default polarity bits give active-high outputs
// RULE5: enabled pins detach port data and direction
// RULE6: unprogrammed reset strap clears pin enables
// RULE7: programmed strap loads 101 or 100 at reset
// RULE8: external fault sources drive inputs low
// RULE9: faults act only while enabled
// RULE10: per-input fault status bit set on fault
// RULE11: latched mode holds until input high, cleared
// RULE12: latched mode resumes at next period start
// RULE13: cycle mode resumes at period, status autoclears
// RULE14: scope one forces all eight outputs inactive
// RULE15: scope zero forces outputs five to zero
// RULE16: shutdown path is pure hardware
// RULE17: override select low follows manual state bit
// RULE18: fault inputs synchronised before any logic
module pwmos_top import pwmos_pkg::*; #(
  parameter int unsigned NUM_OUTPUTS = 8 // 8 or 6 pwm pins bonded
) (
  input  wire logic              i_clk,            // 250 MHz module clock
  input  wire logic              i_rst,            // synchronous reset, active high
  input  wire logic [ADDR_W-1:0] i_addr,           // register byte address
  input  wire logic [DATA_W-1:0] i_wdata,          // register write data
  input  wire logic              i_wr,             // write strobe
  input  wire logic              i_rd,             // read strobe
  output logic      [DATA_W-1:0] o_rdata,          // read data, cycle after i_rd
  input  wire logic              i_high_side_polarity, // strap, 1 = active high
  input  wire logic              i_low_side_polarity,  // strap, 1 = active high
  input  wire logic              i_reset_pin_state_cfg, // strap, 0 = pwm at reset
  input  wire logic              i_fault_in_a_n,   // fault a pin, active low
  input  wire logic              i_fault_in_b_n,   // fault b pin, active low
  input  wire logic [7:0]        i_duty_pwm,       // comparator levels, 1 = active
  input  wire logic              i_period_start,   // one-cycle period start pulse
  input  wire logic [7:0]        i_port_data,      // general port output data
  input  wire logic [7:0]        i_pin_direction_reg, // 1 = input, 0 = output
  input  wire logic [7:0]        i_pin_in,         // pin input levels
  output logic      [7:0]        o_pin_out,        // pin output level
  output logic      [7:0]        o_pin_oe_n,       // low while pin is driven
  output logic                   o_irq             // level interrupt
);

  localparam logic [2:0] PEN_RST = (NUM_OUTPUTS == 8) ? PEN_RST_8 : PEN_RST_6;

  // pin-enable field to pin mask
  function automatic logic [7:0] pen_mask(input logic [2:0] f);
    case (f)
      3'h0:    pen_mask = 8'h00;
      3'h1:    pen_mask = 8'h02;
      3'h2:    pen_mask = 8'h03;
      3'h3:    pen_mask = 8'h0f;
      3'h4:    pen_mask = 8'h3f;
      default: pen_mask = 8'hff;
    endcase
  endfunction

  // active-true level to pin level: odd pins use high side, even low side
  function automatic logic [7:0] apply_pol(input logic [7:0] lvl, input logic hp,
                                           input logic lp);
    for (int i = 0; i < 8; i++) begin
      apply_pol[i] = (i % 2 == 1) ? ~(lvl[i] ^ hp) : ~(lvl[i] ^ lp);
    end
  endfunction

  // two-flop synchronisers for every pin-side input
  // straps stay live; a strap change reaches the pins three edges later
  localparam int unsigned SYNC_W = 13;
  logic [SYNC_W-1:0] sync_meta_r;
  logic [SYNC_W-1:0] sync_r;

  always_ff @(posedge i_clk) begin
    sync_meta_r <= {i_pin_in, i_reset_pin_state_cfg, i_low_side_polarity,
                    i_high_side_polarity, i_fault_in_b_n, i_fault_in_a_n};
    sync_r      <= sync_meta_r; // [RULE18]
  end

  logic       flt_a_n_s;
  logic       flt_b_n_s;
  logic       high_side_polarity_s;
  logic       low_side_polarity_s;
  logic       rstcfg_s;
  logic [7:0] pin_in_s;
  assign flt_a_n_s = sync_r[0];
  assign flt_b_n_s = sync_r[1];
  assign high_side_polarity_s    = sync_r[2];
  assign low_side_polarity_s    = sync_r[3];
  assign rstcfg_s  = sync_r[4];
  assign pin_in_s  = sync_r[12:5];

  // registers
  logic [2:0] pen_r;
  logic       en_a_r;
  logic       en_b_r;
  logic       mode_a_r;
  logic       mode_b_r;
  logic       scope_r;
  logic       stat_a_r;
  logic       stat_b_r;
  logic [7:0] ovr_sel_r;
  logic [7:0] ovr_st_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic       shut_a_r;
  logic       shut_b_r;

  logic wr_ctrl0;
  logic wr_fcfg;
  logic wr_irq_stat;
  assign wr_ctrl0    = i_wr && (i_addr == OFS_CTRL0);
  assign wr_fcfg     = i_wr && (i_addr == OFS_FLT_CFG);
  assign wr_irq_stat = i_wr && (i_addr == OFS_IRQ_STAT);

  // strap sampled through the synchroniser; hold reset three or more edges
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pen_r <= rstcfg_s ? PEN_OFF : PEN_RST; // [RULE6] [RULE7]
    end else if (wr_ctrl0) begin
      pen_r <= i_wdata[2:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      en_a_r   <= 1'b0;
      en_b_r   <= 1'b0;
      mode_a_r <= MODE_LATCHED;
      mode_b_r <= MODE_LATCHED;
      scope_r  <= SCOPE_RST;
    end else if (wr_fcfg) begin
      en_a_r   <= i_wdata[FB_EN_A];
      en_b_r   <= i_wdata[FB_EN_B];
      mode_a_r <= i_wdata[FB_MODE_A];
      mode_b_r <= i_wdata[FB_MODE_B];
      scope_r  <= i_wdata[FB_SCOPE];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ovr_sel_r  <= OVR_CTL_RST;
      ovr_st_r   <= OVR_ST_RST;
      irq_mask_r <= IRQ_MASK_RST;
    end else begin
      if (i_wr && i_addr == OFS_OVR_CTL) begin
        ovr_sel_r <= i_wdata[7:0];
      end
      if (i_wr && i_addr == OFS_OVR_ST) begin
        ovr_st_r <= i_wdata[7:0];
      end
      if (i_wr && i_addr == OFS_IRQ_MASK) begin
        irq_mask_r <= i_wdata[1:0];
      end
    end
  end

  // fault detection, only on the synchronised level
  logic flt_a_act;
  logic flt_b_act;
  assign flt_a_act = en_a_r && !flt_a_n_s; // [RULE8] [RULE9]
  assign flt_b_act = en_b_r && !flt_b_n_s; // [RULE8] [RULE9]

  // status: set wins over software clear and over the period auto-clear
  logic stat_a_nxt;
  logic stat_b_nxt;
  always_comb begin
    stat_a_nxt = stat_a_r;
    stat_b_nxt = stat_b_r;
    if (wr_fcfg && i_wdata[FB_STAT_A]) begin
      stat_a_nxt = 1'b0;
    end
    if (wr_fcfg && i_wdata[FB_STAT_B]) begin
      stat_b_nxt = 1'b0;
    end
    if (mode_a_r == MODE_CYCLE && i_period_start) begin
      stat_a_nxt = 1'b0; // [RULE13]
    end
    if (mode_b_r == MODE_CYCLE && i_period_start) begin
      stat_b_nxt = 1'b0; // [RULE13]
    end
    if (flt_a_act) begin
      stat_a_nxt = 1'b1; // [RULE10]
    end
    if (flt_b_act) begin
      stat_b_nxt = 1'b1; // [RULE10]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_a_r <= 1'b0;
      stat_b_r <= 1'b0;
    end else begin
      stat_a_r <= stat_a_nxt;
      stat_b_r <= stat_b_nxt;
    end
  end

  // shutdown state per input; released on a period start, or at once when the input is disabled
  // no asynchronous bypass: pins come from flops, so shutdown costs four edges
  function automatic logic shut_next(input logic shut, input logic en, input logic act,
                                     input logic mode, input logic stat,
                                     input logic ps);
    if (!en) begin
      shut_next = 1'b0;
    end else if (act) begin
      shut_next = 1'b1;
    end else if (shut && ps && (mode == MODE_CYCLE || !stat)) begin
      shut_next = 1'b0;
    end else begin
      shut_next = shut;
    end
  endfunction

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shut_a_r <= 1'b0;
      shut_b_r <= 1'b0;
    end else begin
      // [RULE11] [RULE12] [RULE13] [RULE16]
      shut_a_r <= shut_next(shut_a_r, en_a_r, flt_a_act, mode_a_r, stat_a_r, i_period_start);
      shut_b_r <= shut_next(shut_b_r, en_b_r, flt_b_act, mode_b_r, stat_b_r, i_period_start);
    end
  end

  // output path
  // forcing acts before polarity, so inactive tracks each pin's polarity
  logic       shut_any;
  logic [7:0] force_mask;
  logic [7:0] lvl;
  logic [7:0] pin_lvl;
  logic [7:0] pen_m;
  assign shut_any   = shut_a_r || shut_b_r;
  assign force_mask = !shut_any ? 8'h00 : (scope_r ? 8'hff : 8'h3f); // [RULE14] [RULE15]
  assign lvl        = ((ovr_sel_r & i_duty_pwm) | (~ovr_sel_r & ovr_st_r)) // [RULE17]
                      & ~force_mask; // [RULE16]
  assign pin_lvl    = apply_pol(lvl, high_side_polarity_s, low_side_polarity_s); // [RULE1] [RULE2] [RULE3] [RULE4]
  assign pen_m      = pen_mask(pen_r);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pin_out  <= 8'h00;
      o_pin_oe_n <= 8'hff;
    end else begin
      // pwm-owned pins ignore port data and direction
      o_pin_out  <= (pen_m & pin_lvl) | (~pen_m & i_port_data); // [RULE5]
      o_pin_oe_n <= ~pen_m & i_pin_direction_reg; // [RULE5]
    end
  end

  // interrupts: rising status is the event; write one to clear, set wins
  logic [1:0] irq_evt;
  assign irq_evt = {stat_b_nxt & ~stat_b_r, stat_a_nxt & ~stat_a_r};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_stat_r <= 2'h0;
      o_irq      <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(wr_irq_stat ? i_wdata[1:0] : 2'h0)) | irq_evt;
      o_irq      <= |(irq_stat_r & irq_mask_r);
    end
  end

  // read port; unmapped addresses read zero
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_rd) begin
      o_rdata <= '0;
    end else begin
      case (i_addr)
        OFS_CTRL0:    o_rdata <= {29'h0, pen_r};
        OFS_FLT_CFG:  o_rdata <= {25'h0, stat_b_r, stat_a_r, scope_r, mode_b_r, mode_a_r,
                                  en_b_r, en_a_r};
        OFS_OVR_CTL:  o_rdata <= {24'h0, ovr_sel_r};
        OFS_OVR_ST:   o_rdata <= {24'h0, ovr_st_r};
        OFS_IRQ_STAT: o_rdata <= {30'h0, irq_stat_r};
        OFS_IRQ_MASK: o_rdata <= {30'h0, irq_mask_r};
        OFS_PIN_STAT: o_rdata <= {16'h0, pin_in_s, 3'h0, shut_b_r, shut_a_r, rstcfg_s,
                                  low_side_polarity_s, high_side_polarity_s};
        default:      o_rdata <= '0;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_high_side_pol: assert property ( // [RULE1]
    (pen_m[1] && !ovr_sel_r[1] && !shut_any)
    |=> o_pin_out[1] == $past(ovr_st_r[1] ~^ high_side_polarity_s))
    else $error("odd pin polarity wrong");

  a_low_side_pol: assert property ( // [RULE2]
    (pen_m[0] && !ovr_sel_r[0] && !shut_any)
    |=> o_pin_out[0] == $past(ovr_st_r[0] ~^ low_side_polarity_s))
    else $error("even pin polarity wrong");

  a_forced_pol: assert property ( // [RULE3]
    (shut_any && pen_m[2]) |=> o_pin_out[2] == !$past(low_side_polarity_s))
    else $error("forced level not polarity referenced");

  a_default_high: assert property ( // [RULE4]
    (high_side_polarity_s && low_side_polarity_s && pen_m[3] && ovr_sel_r[3] && i_duty_pwm[3] && !shut_any)
    |=> o_pin_out[3])
    else $error("default polarity not active high");

  a_port_owns_pin: assert property ( // [RULE5]
    !pen_m[4] |=> (o_pin_out[4] == $past(i_port_data[4]))
                  && (o_pin_oe_n[4] == $past(i_pin_direction_reg[4])))
    else $error("port control lost on disabled pin");

  a_pwm_owns_pin: assert property ( // [RULE5]
    pen_m[5] |=> !o_pin_oe_n[5])
    else $error("pwm pin not driven");

  a_reset_strap: assert property ( // [RULE6] [RULE7]
    ($past(i_rst) && !i_rst) |-> pen_r == ($past(rstcfg_s) ? PEN_OFF : PEN_RST))
    else $error("pin enable reset value wrong");

  a_fault_disabled: assert property ( // [RULE9]
    (!en_a_r && !en_b_r) |=> !shut_any)
    else $error("disabled fault affected outputs");

  a_status_set: assert property ( // [RULE10]
    flt_a_act |=> stat_a_r)
    else $error("fault a status not set");

  a_latched_hold: assert property ( // [RULE11]
    (shut_a_r && en_a_r && mode_a_r == MODE_LATCHED && stat_a_r) |=> shut_a_r)
    else $error("latched shutdown released early");

  a_latched_resume: assert property ( // [RULE12]
    (shut_a_r && !shut_b_r && mode_a_r == MODE_LATCHED && !stat_a_r && !flt_a_act
     && !flt_b_act && i_period_start) |=> !shut_a_r)
    else $error("latched shutdown not released at period");

  a_cycle_resume: assert property ( // [RULE13]
    (shut_b_r && mode_b_r == MODE_CYCLE && !flt_b_act && i_period_start)
    |=> !shut_b_r && !stat_b_r)
    else $error("cycle mode did not resume");

  a_scope_all: assert property ( // [RULE14]
    (shut_any && scope_r && pen_m[7]) |=> o_pin_out[7] == !$past(high_side_polarity_s))
    else $error("pin 7 not forced with scope one");

  a_scope_low: assert property ( // [RULE15]
    (shut_any && !scope_r && pen_m[7])
    |=> o_pin_out[7] == $past(((ovr_sel_r[7] && i_duty_pwm[7])
                               || (!ovr_sel_r[7] && ovr_st_r[7])) ~^ high_side_polarity_s))
    else $error("pin 7 disturbed with scope zero");

  a_fault_latency: assert property ( // [RULE16] [RULE18]
    (flt_a_act && pen_m[1] && scope_r) |-> ##2 o_pin_out[1] == !$past(high_side_polarity_s))
    else $error("fault shutdown too slow");

  a_manual_state: assert property ( // [RULE17]
    (pen_m[4] && !ovr_sel_r[4] && ovr_st_r[4] && !shut_any) |=> o_pin_out[4] == $past(low_side_polarity_s))
    else $error("manual active state not driven");

  c_latched_cycle: cover property (
    shut_a_r && mode_a_r == MODE_LATCHED ##[1:200] !shut_a_r);
  c_cycle_mode:    cover property (
    shut_b_r && mode_b_r == MODE_CYCLE ##[1:200] !shut_b_r);
  c_manual_out:    cover property (pen_m[0] && !ovr_sel_r[0] && ovr_st_r[0]);
  c_irq_raised:    cover property (!o_irq ##1 o_irq);

endmodule
